// *** inc/mot_pkg.sv ***
// shared types and constants of the management overhead transport block
// assumes a single 250 MHz clock and same-clock neighbours on every port
package mot_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_KHZ = 250_000;
	localparam int RESP_LIMIT_MS = 50;
	localparam int RESP_LIMIT_CYC = RESP_LIMIT_MS * CLK_KHZ;
	// own answer deadline, kept below the hard limit for margin
	localparam int ANSWER_DEADLINE_MS = 40;
	localparam int ANSWER_DEADLINE_CYC = ANSWER_DEADLINE_MS * CLK_KHZ;
	localparam int TIMER_W = 24;

	// ****************************************
	// message layout
	// ****************************************
	localparam int DATA_W = 32;
	localparam int NPRIO = 3;
	localparam int BUF_DEPTH = 2;
	localparam logic [7:0] OP_ONLINE_RECONFIG = 8'h01;
	localparam logic [7:0] OP_CLEAR_EOC = 8'h08;
	localparam int OP_LOW_PRIO_BIT = 7;
	localparam logic [DATA_W-1:0] DATA_REJECT = 32'h0000_00ff;
	localparam logic [DATA_W-1:0] DATA_ACK = 32'h0000_0000;

	localparam logic [1:0] PRIO_HIGH = 2'h0;
	localparam logic [1:0] PRIO_NORMAL = 2'h1;
	localparam logic [1:0] PRIO_LOW = 2'h2;

	typedef enum logic [0:0] {
		KIND_CMD = 1'b0,
		KIND_RSP = 1'b1
	} mot_kind_t;

	typedef enum logic [1:0] {
		SLOT_IDLE = 2'b00,
		SLOT_WAIT = 2'b01,
		SLOT_SEND = 2'b10
	} mot_slot_t;

	typedef struct packed {
		mot_kind_t kind;
		logic [7:0] opcode;
		logic [DATA_W-1:0] data;
	} mot_msg_t;

	function automatic logic [1:0] prio_of(input logic [7:0] op);
		logic [1:0] p;
		p = PRIO_NORMAL;
		if (op == OP_ONLINE_RECONFIG) begin
			p = PRIO_HIGH;
		end else if (op[OP_LOW_PRIO_BIT]) begin
			p = PRIO_LOW;
		end
		return p;
	endfunction

endpackage

// *** hw/mot_pair_buf.sv ***
// small valid/ready buffer in the transmit path toward the transport layer
// assumes the drain side may stall freely; ready tells the filler
`timescale 1ns/1ps
`default_nettype none
module mot_pair_buf #(
	parameter int WIDTH = 41,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [CW-1:0] count_q, count_d;
	logic push, pop;
	logic [WIDTH-1:0] headNext;

	// ****************************************
	// pointers and fill level
	// ****************************************
	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (push) begin
			wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_q + 1'b1);
		end
		if (pop) begin
			rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_q + 1'b1);
		end
		if (push && !pop) begin
			count_d = CW'(count_q + 1'b1);
		end else if (pop && !push) begin
			count_d = CW'(count_q - 1'b1);
		end
		// head word kept in a flop; a push into the new head slot bypasses mem
		headNext = mem[rdPtr_d];
		if (push && wrPtr_q == rdPtr_d) begin
			headNext = inData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			outValid <= 1'b0;
			inReady <= 1'b0;
			outData <= '0;
		end else if (clkEn) begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			outValid <= (count_d != '0);
			inReady <= (count_d != CW'(DEPTH));
			outData <= headNext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clkEn && push) begin
			mem[wrPtr_q] <= inData;
		end
	end

endmodule
`default_nettype wire

// *** hw/mot_transport.sv ***
// management overhead transport: clear channel and command exchange
// between the local management function and the transport layer
// assumes every neighbour runs on sys_clk; rx frames already checked
//
// Function
// - clear channel requests accepted and queued outward
// - confirm each accepted request, paced by buffer
// - deliver received clear channel messages upward
// - send management command requests to far end
// - pass far-end answers back as command confirm
// - indicate received far-end commands to local logic
// - send local answers back to the far end
// - three priority levels, highest offered first
// - a received command is answered unless its priority level is busy, then dropped
// - frames flagged discarded are dropped unanswered
// - answer queued by the deadline, 40 ms by default; the send still waits on arbiter and stall
// - either end may originate commands
// - reconfig answered by sync flag or reject
`timescale 1ns/1ps
`default_nettype none
module mot_transport #(
	parameter logic [mot_pkg::TIMER_W-1:0] CMD_TIMEOUT_CYC =
		mot_pkg::TIMER_W'(mot_pkg::RESP_LIMIT_CYC),
	parameter logic [mot_pkg::TIMER_W-1:0] ANSWER_DEADLINE_CYC =
		mot_pkg::TIMER_W'(mot_pkg::ANSWER_DEADLINE_CYC)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic ceReqValid,
	input wire logic [mot_pkg::DATA_W-1:0] ceReqData,
	output logic ceConfirm,
	output logic ceIndValid,
	output logic [mot_pkg::DATA_W-1:0] ceIndData,
	input wire logic cmdReqValid,
	input wire mot_pkg::mot_msg_t cmdReqMsg,
	output logic cmdReqAccept,
	output logic cmdCfmValid,
	output mot_pkg::mot_msg_t cmdCfmMsg,
	output logic cmdTimeout,
	output logic [1:0] cmdTimeoutPrio,
	output logic cmdIndValid,
	output mot_pkg::mot_msg_t cmdIndMsg,
	input wire logic rspValid,
	input wire mot_pkg::mot_msg_t rspMsg,
	input wire logic rspSync,
	output logic syncFlagOut,
	output logic txValid,
	output mot_pkg::mot_msg_t txMsg,
	input wire logic txReady,
	input wire logic rxValid,
	input wire mot_pkg::mot_msg_t rxMsg,
	input wire logic rxDiscard
);
	localparam int NP = mot_pkg::NPRIO;
	localparam int TW = mot_pkg::TIMER_W;

	// ****************************************
	// state
	// ****************************************
	mot_pkg::mot_slot_t slot_q [NP];
	mot_pkg::mot_slot_t slot_d [NP];
	mot_pkg::mot_msg_t slotMsg_q [NP];
	mot_pkg::mot_msg_t slotMsg_d [NP];
	logic [TW-1:0] inTimer_q [NP];
	logic [TW-1:0] inTimer_d [NP];
	logic [NP-1:0] outst_q, outst_d;
	logic [TW-1:0] outTimer_q [NP];
	logic [TW-1:0] outTimer_d [NP];
	logic ceAckPend_q, ceAckPend_d;

	logic ceConfirm_d, ceIndValid_d, cmdReqAccept_d, cmdCfmValid_d;
	logic cmdTimeout_d, cmdIndValid_d, syncFlagOut_d;
	logic [mot_pkg::DATA_W-1:0] ceIndData_d;
	mot_pkg::mot_msg_t cmdCfmMsg_d, cmdIndMsg_d;
	logic [1:0] cmdTimeoutPrio_d;

	logic bufInReady, push;
	mot_pkg::mot_msg_t pushMsg;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [1:0] rp;
		logic [1:0] lp;
		logic [1:0] cp;
		logic granted;
		logic toSeen;
		rp = mot_pkg::prio_of(rxMsg.opcode);
		lp = mot_pkg::prio_of(rspMsg.opcode);
		cp = mot_pkg::prio_of(cmdReqMsg.opcode);
		granted = 1'b0;
		toSeen = 1'b0;
		slot_d = slot_q;
		slotMsg_d = slotMsg_q;
		inTimer_d = inTimer_q;
		outst_d = outst_q;
		outTimer_d = outTimer_q;
		ceAckPend_d = ceAckPend_q;
		ceConfirm_d = 1'b0;
		ceIndValid_d = 1'b0;
		ceIndData_d = ceIndData;
		cmdReqAccept_d = 1'b0;
		cmdCfmValid_d = 1'b0;
		cmdCfmMsg_d = cmdCfmMsg;
		cmdTimeout_d = 1'b0;
		cmdTimeoutPrio_d = cmdTimeoutPrio;
		cmdIndValid_d = 1'b0;
		cmdIndMsg_d = cmdIndMsg;
		syncFlagOut_d = 1'b0;
		push = 1'b0;
		pushMsg = '0;

		// receive side; flagged frames never reach command handling
		if (rxValid && !rxDiscard) begin
			if (rxMsg.kind == mot_pkg::KIND_CMD) begin
				if (rxMsg.opcode == mot_pkg::OP_CLEAR_EOC) begin
					ceIndValid_d = 1'b1;
					ceIndData_d = rxMsg.data;
					ceAckPend_d = 1'b1;
				end else if (slot_q[rp] == mot_pkg::SLOT_IDLE) begin
					slot_d[rp] = mot_pkg::SLOT_WAIT;
					slotMsg_d[rp] = rxMsg;
					inTimer_d[rp] = '0;
					cmdIndValid_d = 1'b1;
					cmdIndMsg_d = rxMsg;
				end
			end else if (rxMsg.opcode != mot_pkg::OP_CLEAR_EOC && outst_q[rp]) begin
				// answer frees the level for the next command
				outst_d[rp] = 1'b0;
				cmdCfmValid_d = 1'b1;
				cmdCfmMsg_d = rxMsg;
			end
		end

		// local answer to an indicated command
		if (rspValid && slot_q[lp] == mot_pkg::SLOT_WAIT) begin
			if (rspSync && rspMsg.opcode == mot_pkg::OP_ONLINE_RECONFIG) begin
				slot_d[lp] = mot_pkg::SLOT_IDLE;
				syncFlagOut_d = 1'b1;
			end else begin
				slot_d[lp] = mot_pkg::SLOT_SEND;
				slotMsg_d[lp] = rspMsg;
				slotMsg_d[lp].kind = mot_pkg::KIND_RSP;
			end
		end

		// answer deadline: silence from local logic becomes a reject
		for (int i = 0; i < NP; i++) begin
			case (slot_d[i])
				mot_pkg::SLOT_WAIT: begin
					if (slot_q[i] == mot_pkg::SLOT_WAIT) begin
						if (inTimer_q[i] == TW'(ANSWER_DEADLINE_CYC - 1'b1)) begin
							slot_d[i] = mot_pkg::SLOT_SEND;
							slotMsg_d[i].kind = mot_pkg::KIND_RSP;
							slotMsg_d[i].data = mot_pkg::DATA_REJECT;
						end else begin
							inTimer_d[i] = inTimer_q[i] + 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// outstanding command timers; one report per cycle, rest hold
		for (int i = 0; i < NP; i++) begin
			if (outst_q[i] && outst_d[i]) begin
				if (outTimer_q[i] == TW'(CMD_TIMEOUT_CYC - 1'b1)) begin
					if (!toSeen) begin
						toSeen = 1'b1;
						outst_d[i] = 1'b0;
						cmdTimeout_d = 1'b1;
						cmdTimeoutPrio_d = 2'(i);
					end
				end else begin
					outTimer_d[i] = outTimer_q[i] + 1'b1;
				end
			end
		end

		// transmit arbiter, strictly by decreasing priority
		if (bufInReady) begin
			for (int i = 0; i < NP; i++) begin
				if (!granted && slot_q[i] == mot_pkg::SLOT_SEND) begin
					granted = 1'b1;
					push = 1'b1;
					pushMsg = slotMsg_q[i];
					slot_d[i] = mot_pkg::SLOT_IDLE;
				end
				if (!granted && cmdReqValid && !cmdReqAccept && cp == 2'(i)
					&& !outst_q[i]) begin
					granted = 1'b1;
					push = 1'b1;
					pushMsg = cmdReqMsg;
					pushMsg.kind = mot_pkg::KIND_CMD;
					outst_d[i] = 1'b1;
					outTimer_d[i] = '0;
					cmdReqAccept_d = 1'b1;
				end
				if (!granted && 2'(i) == mot_pkg::PRIO_NORMAL && ceAckPend_q) begin
					granted = 1'b1;
					push = 1'b1;
					pushMsg.kind = mot_pkg::KIND_RSP;
					pushMsg.opcode = mot_pkg::OP_CLEAR_EOC;
					pushMsg.data = mot_pkg::DATA_ACK;
					ceAckPend_d = 1'b0;
				end
				if (!granted && 2'(i) == mot_pkg::PRIO_NORMAL && ceReqValid
					&& !ceConfirm) begin
					granted = 1'b1;
					push = 1'b1;
					pushMsg.kind = mot_pkg::KIND_CMD;
					pushMsg.opcode = mot_pkg::OP_CLEAR_EOC;
					pushMsg.data = ceReqData;
					ceConfirm_d = 1'b1;
				end
			end
		end
		// a new clear channel command arriving while its ack leaves wins
		if (rxValid && !rxDiscard && rxMsg.kind == mot_pkg::KIND_CMD
			&& rxMsg.opcode == mot_pkg::OP_CLEAR_EOC) begin
			ceAckPend_d = 1'b1;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NP; i++) begin
				slot_q[i] <= mot_pkg::SLOT_IDLE;
				slotMsg_q[i] <= '0;
				inTimer_q[i] <= '0;
				outTimer_q[i] <= '0;
			end
			outst_q <= '0;
			ceAckPend_q <= 1'b0;
			ceConfirm <= 1'b0;
			ceIndValid <= 1'b0;
			ceIndData <= '0;
			cmdReqAccept <= 1'b0;
			cmdCfmValid <= 1'b0;
			cmdCfmMsg <= '0;
			cmdTimeout <= 1'b0;
			cmdTimeoutPrio <= '0;
			cmdIndValid <= 1'b0;
			cmdIndMsg <= '0;
			syncFlagOut <= 1'b0;
		end else if (clkEn) begin
			slot_q <= slot_d;
			slotMsg_q <= slotMsg_d;
			inTimer_q <= inTimer_d;
			outTimer_q <= outTimer_d;
			outst_q <= outst_d;
			ceAckPend_q <= ceAckPend_d;
			ceConfirm <= ceConfirm_d;
			ceIndValid <= ceIndValid_d;
			ceIndData <= ceIndData_d;
			cmdReqAccept <= cmdReqAccept_d;
			cmdCfmValid <= cmdCfmValid_d;
			cmdCfmMsg <= cmdCfmMsg_d;
			cmdTimeout <= cmdTimeout_d;
			cmdTimeoutPrio <= cmdTimeoutPrio_d;
			cmdIndValid <= cmdIndValid_d;
			cmdIndMsg <= cmdIndMsg_d;
			syncFlagOut <= syncFlagOut_d;
		end
	end

	// ****************************************
	// outgoing buffer
	// ****************************************
	// stall by the transport layer backs up into the arbiter, not lost
	mot_pair_buf #(
		.WIDTH($bits(mot_pkg::mot_msg_t)),
		.DEPTH(mot_pkg::BUF_DEPTH)
	) mot_pair_buf_inst (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.inValid(push),
		.inReady(bufInReady),
		.inData(pushMsg),
		.outValid(txValid),
		.outReady(txReady),
		.outData(txMsg)
	);
endmodule
`default_nettype wire

// *** test/mot_transport_properties.sv ***
// port checker of the overhead transport block
// assumes clkEn stays high while the checks run
`timescale 1ns/1ps
`default_nettype none
module mot_transport_properties #(
	parameter logic [mot_pkg::TIMER_W-1:0] ANSWER_DEADLINE_CYC =
		mot_pkg::TIMER_W'(mot_pkg::ANSWER_DEADLINE_CYC)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ceReqValid,
	input wire logic ceConfirm,
	input wire logic ceIndValid,
	input wire logic cmdCfmValid,
	input wire logic cmdTimeout,
	input wire logic cmdIndValid,
	input wire logic rspValid,
	input wire mot_pkg::mot_msg_t rspMsg,
	input wire logic rspSync,
	input wire logic syncFlagOut,
	input wire logic txValid,
	input wire mot_pkg::mot_msg_t txMsg,
	input wire logic txReady,
	input wire logic rxValid,
	input wire mot_pkg::mot_msg_t rxMsg,
	input wire logic rxDiscard
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ****
	// answer wait counter
	// ****
	logic [mot_pkg::TIMER_W-1:0] ansWait_q;
	logic [mot_pkg::TIMER_W-1:0] ansWait_d;
	always_comb begin
		ansWait_d = ansWait_q;
		// a sync flag answer sends no word, so it also ends the wait
		if (sys_rst || (txValid && txMsg.kind == mot_pkg::KIND_RSP) || syncFlagOut) begin
			ansWait_d = '0;
		end else if (cmdIndValid || ansWait_q != '0) begin
			ansWait_d = ansWait_q + 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		ansWait_q <= ansWait_d;
	end
	// ****
	// assertions
	// ****
	ce_confirm_pulse_a: assert property (ceConfirm |=> !ceConfirm)
		else $error("confirm held too long");
	ce_confirm_cause_a: assert property (ceConfirm |-> $past(ceReqValid))
		else $error("confirm without request");
	clear_deliver_a: assert property (
		rxValid && !rxDiscard && rxMsg.kind == mot_pkg::KIND_CMD
		&& rxMsg.opcode == mot_pkg::OP_CLEAR_EOC |=> ceIndValid)
		else $error("clear message not delivered");
	cmd_ind_cause_a: assert property (cmdIndValid |->
		$past(rxValid && !rxDiscard && rxMsg.kind == mot_pkg::KIND_CMD))
		else $error("indication without command");
	discard_drop_a: assert property (rxValid && rxDiscard |=>
		!(ceIndValid || cmdIndValid || cmdCfmValid))
		else $error("discarded frame used");
	cfm_cause_a: assert property (cmdCfmValid |->
		$past(rxValid && !rxDiscard && rxMsg.kind == mot_pkg::KIND_RSP))
		else $error("confirm without answer");
	sync_flag_a: assert property (syncFlagOut |->
		$past(rspValid && rspSync && rspMsg.opcode == mot_pkg::OP_ONLINE_RECONFIG))
		else $error("stray sync flag");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txMsg))
		else $error("stalled word changed");
	answer_deadline_a: assert property (ansWait_q <= ANSWER_DEADLINE_CYC + 4)
		else $error("answer too late");
	cover property (cmdTimeout);
	cover property (syncFlagOut);
	cover property (txValid && !txReady);
endmodule
bind mot_transport mot_transport_properties #(.ANSWER_DEADLINE_CYC(ANSWER_DEADLINE_CYC))
	mot_transport_properties_inst (.sys_clk, .sys_rst, .ceReqValid, .ceConfirm, .ceIndValid,
	.cmdCfmValid, .cmdTimeout, .cmdIndValid, .rspValid, .rspMsg, .rspSync, .syncFlagOut,
	.txValid, .txMsg, .txReady, .rxValid, .rxMsg, .rxDiscard);
`default_nettype wire

// *** test/mot_far_end.sv ***
// transport layer model: sinks outgoing words, sends received frames
// assumes the bench calls send and sets stall at falling edges
`timescale 1ns/1ps
`default_nettype none
module mot_far_end (
	input wire logic sys_clk,
	input wire logic txValid,
	input wire mot_pkg::mot_msg_t txMsg,
	output logic txReady,
	output logic rxValid,
	output mot_pkg::mot_msg_t rxMsg,
	output logic rxDiscard
);
	logic stall = 1'b0;
	mot_pkg::mot_msg_t got[$];
	initial begin
		rxValid = 1'b0;
		rxMsg = '0;
		rxDiscard = 1'b0;
	end
	assign txReady = !stall;
	always @(posedge sys_clk) begin
		if (txValid && txReady) begin
			got.push_back(txMsg);
		end
	end
	task automatic send(input logic [40:0] m, input logic bad);
		@(negedge sys_clk);
		rxValid = 1'b1;
		rxDiscard = bad;
		rxMsg = m;
		@(negedge sys_clk);
		rxValid = 1'b0;
		// idle lines never repeat the last word
		rxDiscard = !bad;
		rxMsg = ~m;
	endtask
endmodule
`default_nettype wire

// *** test/mot_transport_test.sv ***
// self-checking bench of the overhead transport block
// far end is the transport layer model; clock enable held high
`timescale 1ns/1ps
`default_nettype none
module mot_transport_test;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	logic ceReqValid = 1'b0;
	logic cmdReqValid = 1'b0;
	logic rspValid = 1'b0;
	logic rspSync = 1'b0;
	logic [31:0] ceReqData = 32'h0;
	mot_pkg::mot_msg_t cmdReqMsg = '0;
	mot_pkg::mot_msg_t rspMsg = '0;
	mot_pkg::mot_msg_t cmdCfmMsg, cmdIndMsg, txMsg, rxMsg;
	logic ceConfirm, ceIndValid, cmdReqAccept, cmdCfmValid, cmdTimeout, cmdIndValid;
	logic syncFlagOut, txValid, txReady, rxValid, rxDiscard, s;
	logic [31:0] ceIndData;
	logic [1:0] cmdTimeoutPrio;
	int nFail = 0;
	int numChecks = 0;
	int n;
	always #2 sys_clk = ~sys_clk;
	mot_transport #(.CMD_TIMEOUT_CYC(24'h0000c8), .ANSWER_DEADLINE_CYC(24'h000064))
		mot_transport_inst (.sys_clk, .sys_rst, .clkEn, .ceReqValid, .ceReqData, .ceConfirm,
		.ceIndValid, .ceIndData, .cmdReqValid, .cmdReqMsg, .cmdReqAccept, .cmdCfmValid,
		.cmdCfmMsg, .cmdTimeout, .cmdTimeoutPrio, .cmdIndValid, .cmdIndMsg, .rspValid,
		.rspMsg, .rspSync, .syncFlagOut, .txValid, .txMsg, .txReady, .rxValid, .rxMsg,
		.rxDiscard);
	mot_far_end mot_far_end_inst (.sys_clk, .txValid, .txMsg, .txReady, .rxValid, .rxMsg,
		.rxDiscard);
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [40:0] got, input logic [40:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic expTx(input logic [40:0] m);
		mot_pkg::mot_msg_t g;
		for (int i = 0; i < 400 && mot_far_end_inst.got.size() == 0; i++) @(negedge sys_clk);
		if (mot_far_end_inst.got.size() != 0) g = mot_far_end_inst.got.pop_front();
		chk(g, m);
	endtask
	task automatic ceReq(input logic [31:0] d, input int lim, output logic seen);
		seen = 1'b0;
		@(negedge sys_clk);
		ceReqValid = 1'b1;
		ceReqData = d;
		for (int i = 0; i < lim && !seen; i++) begin
			@(negedge sys_clk);
			seen = (ceConfirm === 1'b1);
		end
		ceReqValid = !seen;
	endtask
	task automatic cmdReq(input logic [7:0] op, input int lim, output logic seen);
		seen = 1'b0;
		@(negedge sys_clk);
		cmdReqValid = 1'b1;
		cmdReqMsg = {1'h0, op, 24'h0000c0, op};
		for (int i = 0; i < lim && !seen; i++) begin
			@(negedge sys_clk);
			seen = (cmdReqAccept === 1'b1);
		end
		cmdReqValid = !seen;
	endtask
	task automatic rsp(input logic [40:0] m, input logic sy);
		rspValid = 1'b1;
		rspSync = sy;
		rspMsg = m;
		@(negedge sys_clk);
		rspValid = 1'b0;
		rspSync = 1'b0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic tClear();
		mot_far_end_inst.stall = 1'b1;
		ceReq(32'h0000_0a00, 20, s);
		chk(s, 1'h1);
		ceReq(32'h0000_0a01, 20, s);
		chk(s, 1'h1);
		// buffer full: third request must wait
		ceReq(32'h0000_0a02, 20, s);
		chk(s, 1'h0);
		mot_far_end_inst.stall = 1'b0;
		ceReq(32'h0000_0a02, 20, s);
		chk(s, 1'h1);
		for (int i = 0; i < 3; i++) expTx({9'h008, 32'h0000_0a00 + i});
	endtask
	task automatic tClearRx();
		mot_far_end_inst.send({9'h008, 32'h1234_5678}, 1'b0);
		chk(ceIndValid, 1'h1);
		chk(ceIndData, 32'h1234_5678);
		expTx({9'h108, mot_pkg::DATA_ACK});
		mot_far_end_inst.send({9'h041, 32'h0000_0001}, 1'b1);
		chk(cmdIndValid, 1'h0);
		repeat (120) @(negedge sys_clk);
		chk(mot_far_end_inst.got.size(), 41'h0);
	endtask
	task automatic tCmd();
		cmdReq(8'h05, 10, s);
		chk(s, 1'h1);
		expTx({9'h005, 32'h0000_c005});
		cmdReq(8'h06, 150, s);
		chk(s, 1'h0);
		for (n = 0; n < 100 && cmdTimeout !== 1'b1; n++) @(negedge sys_clk);
		chk(n >= 38 && n <= 55, 1'h1);
		chk(cmdTimeoutPrio, mot_pkg::PRIO_NORMAL);
		// the refused request is still held; it is taken the edge after the timeout
		@(negedge sys_clk);
		chk(cmdReqAccept, 1'h1);
		cmdReqValid = 1'b0;
		expTx({9'h006, 32'h0000_c006});
		mot_far_end_inst.send({9'h106, 32'h0000_beef}, 1'b0);
		chk(cmdCfmValid, 1'h1);
		chk(cmdCfmMsg, {9'h106, 32'h0000_beef});
	endtask
	task automatic tPrio();
		mot_far_end_inst.stall = 1'b1;
		ceReq(32'h0000_0b00, 20, s);
		ceReq(32'h0000_0b01, 20, s);
		@(negedge sys_clk);
		ceReqValid = 1'b1;
		ceReqData = 32'h0000_0b02;
		cmdReqValid = 1'b1;
		cmdReqMsg = {9'h001, 32'h0000_c001};
		repeat (3) @(negedge sys_clk);
		mot_far_end_inst.stall = 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(negedge sys_clk);
			if (ceConfirm === 1'b1) ceReqValid = 1'b0;
			if (cmdReqAccept === 1'b1) cmdReqValid = 1'b0;
		end
		expTx({9'h008, 32'h0000_0b00});
		expTx({9'h008, 32'h0000_0b01});
		expTx({9'h001, 32'h0000_c001});
		expTx({9'h008, 32'h0000_0b02});
		mot_far_end_inst.send({9'h101, 32'h0000_0000}, 1'b0);
		chk(cmdCfmValid, 1'h1);
	endtask
	task automatic tCmdIn();
		mot_far_end_inst.send({9'h041, 32'h0000_0041}, 1'b0);
		chk(cmdIndValid, 1'h1);
		chk(cmdIndMsg, {9'h041, 32'h0000_0041});
		rsp({9'h141, 32'h0000_5a5a}, 1'b0);
		expTx({9'h141, 32'h0000_5a5a});
		mot_far_end_inst.send({9'h081, 32'h0000_0002}, 1'b0);
		chk(cmdIndValid, 1'h1);
		expTx({9'h181, mot_pkg::DATA_REJECT});
	endtask
	task automatic tOlr();
		mot_far_end_inst.send({9'h001, 32'h0000_0003}, 1'b0);
		rsp({9'h101, 32'h0000_0000}, 1'b1);
		chk(syncFlagOut, 1'h1);
		repeat (5) @(negedge sys_clk);
		chk(mot_far_end_inst.got.size(), 41'h0);
		mot_far_end_inst.send({9'h001, 32'h0000_0004}, 1'b0);
		rsp({9'h101, mot_pkg::DATA_REJECT}, 1'b0);
		expTx({9'h101, mot_pkg::DATA_REJECT});
	endtask
	task automatic summarize();
		if (nFail == 0 && numChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		tClear();
		tClearRx();
		tCmd();
		tPrio();
		tCmdIn();
		tOlr();
		summarize();
	end
	// whole run needs well under 2000 cycles
	initial begin
		#40000;
		nFail++;
		summarize();
	end
endmodule
`default_nettype wire
